// ### ftlbm_chk.sv
/*
 * Checker for the mapper's link outputs: qualifier placement, spare input,
 * strobes, data stability and reset state.
 * Assumes it is bound onto ftlbm_mapper, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ftlbm_chk (
   input wire        clk,      // system clock
   input wire        nrst,     // async reset, active low
   input wire        psel,     // apb select
   input wire        penable,  // apb access phase
   input wire        pready,   // apb ready
   input wire [27:0] tx_x_in,  // transmitter x inputs
   input wire [27:0] tx_y_in,  // transmitter y inputs
   input wire        tx_x_clk, // strobe x
   input wire        tx_y_clk  // strobe y
);
// ************************************************************
// link checks
// ************************************************************
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
qual_dup_a: assert property (tx_x_in[26:24] == tx_y_in[26:24])
   else $error("qualifiers differ between transmitters");
spare_low_a: assert property (!tx_x_in[23] && !tx_y_in[23])
   else $error("spare input driven");
strobe_pair_a: assert property (tx_x_clk == tx_y_clk)
   else $error("strobes differ");
// receiver samples on the strobe, so data must not move there
data_hold_a: assert property ($rose(tx_x_clk) |-> $stable(tx_x_in) && $stable(tx_y_in))
   else $error("link word changed at strobe edge");
idle_zero_a: assert property (!tx_x_in[26] |-> {tx_x_in[27], tx_x_in[22:0]} == 24'h0
   && {tx_y_in[27], tx_y_in[22:0]} == 24'h0) else $error("data while not valid");
dval_line_a: assert property (tx_x_in[26] |-> tx_x_in[24])
   else $error("data valid outside line");
line_start_a: assert property ($rose(tx_x_in[24]) |-> tx_x_in[26])
   else $error("line began without data");
reset_zero_a: assert property (disable iff (1'b0) !nrst |-> ##1 (nrst
   || (tx_x_in == 28'h0 && tx_y_in == 28'h0))) else $error("outputs not cleared in reset");
cover property ($rose(tx_x_in[24]));
cover property ($fell(tx_x_in[24]));
cover property (psel && penable && pready);
endmodule
bind ftlbm_mapper ftlbm_chk ftlbm_chk_i (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pready(pready), .tx_x_in(tx_x_in), .tx_y_in(tx_y_in),
   .tx_x_clk(tx_x_clk), .tx_y_clk(tx_y_clk));
`default_nettype wire

// ### ftlbm_consts.vh
/*
 * Constants for the four-tap link bit mapper: register map, control
 * fields, depth and line-mode codes, transmitter input positions.
 * Assumes inclusion by bare name from the mapper and its FIFO.
 */
`ifndef FTLBM_CONSTS_VH
`define FTLBM_CONSTS_VH

// ************************************************************
// widths
// ************************************************************
`define FTL_TAP_W        12
`define FTL_TAPS         4
`define FTL_PIX_W        48
`define FTL_WORD_W       49
`define FTL_LAST_BIT     48
`define FTL_FIFO_DEPTH   8
`define FTL_FIFO_AW      3
`define FTL_LINK_W       28
`define FTL_ADDR_W       8

// ************************************************************
// register map (byte addresses)
// ************************************************************
`define FTL_REG_CTRL     8'h00
`define FTL_REG_DELAY    8'h04
`define FTL_REG_STATUS   8'h08
`define FTL_CTRL_RST     5'h00
`define FTL_DELAY_RST    16'h0000

// control fields
`define FTL_CTRL_EN      0
`define FTL_CTRL_DEP_LO  1
`define FTL_CTRL_DEP_HI  2
`define FTL_CTRL_MOD_LO  3
`define FTL_CTRL_MOD_HI  4

// status fields
`define FTL_ST_ACTIVE    0
`define FTL_ST_EMPTY     1
`define FTL_ST_FULL      2
`define FTL_ST_CNT_LO    4
`define FTL_ST_CNT_HI    7
`define FTL_ST_LINES_LO  16
`define FTL_ST_LINES_HI  31

// ************************************************************
// depth and line-mode codes
// ************************************************************
`define FTL_DEP_12       2'h0
`define FTL_DEP_10       2'h1
`define FTL_DEP_8        2'h2
`define FTL_DROP_10      2
`define FTL_DROP_8       4
`define FTL_MODE_RGB     2'h0
`define FTL_MODE_RAW     2'h1
`define FTL_MODE_ERAW    2'h2

// ************************************************************
// transmitter input positions, port bit 7 index leftmost
// ************************************************************
`define FTL_MAP_A  {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`define FTL_MAP_B  {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07}
`define FTL_MAP_C  {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f}
`define FTL_TX_SPARE     23
`define FTL_TX_LVAL      24
`define FTL_TX_FVAL      25
`define FTL_TX_DVAL      26

`endif

// ### ftlbm_fg_model.sv
/*
 * Frame grabber model: takes both link words at each rising strobe and
 * passes on only the words that the qualifiers mark as pixel data.
 * Assumes the strobe is a register on clk, so plain edge detection works.
 */
`timescale 1ns/1ps
`default_nettype none
module ftlbm_fg_model (
   input  wire        clk,       // system clock
   input  wire        nrst,      // async reset, active low
   input  wire        strobe,    // transmitter strobe
   input  wire        raw_mode,  // frame valid expected
   input  wire [27:0] x_in,      // transmitter x word
   input  wire [27:0] y_in,      // transmitter y word
   output logic       acc_valid, // accepted word pulse
   output logic [27:0] acc_x,    // accepted x word
   output logic [27:0] acc_y     // accepted y word
);
// ************************************************************
// receiver
// ************************************************************
logic strobe_ff;
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      strobe_ff <= 1'b0;
      acc_valid <= 1'b0;
      acc_x     <= 28'h0;
      acc_y     <= 28'h0;
   end
   else
   begin
      strobe_ff <= strobe;
      // lval, dval and in raw modes fval must all be high
      acc_valid <= strobe && !strobe_ff && x_in[24] && x_in[26]
         && (x_in[25] || !raw_mode);
      acc_x     <= x_in;
      acc_y     <= y_in;
   end
end
endmodule
`default_nettype wire

// ### ftlbm_fifo.v
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock, asynchronous active-low reset, clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftlbm_consts.vh"

module ftlbm_fifo #(
   parameter WIDTH = `FTL_WORD_W,
   parameter DEPTH = `FTL_FIFO_DEPTH,
   parameter AW    = `FTL_FIFO_AW
) (
   input  wire             clk,       // system clock
   input  wire             nrst,      // async reset, active low
   input  wire             ce,        // clock enable
   input  wire             in_valid,  // write request
   output wire             in_ready,  // space available
   input  wire [WIDTH-1:0] in_data,   // write word
   output wire             out_valid, // word available
   input  wire             out_ready, // read accept
   output wire [WIDTH-1:0] out_data,  // head word
   output wire [AW:0]      level      // words held
);

   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      cnt_ff;
   wire            push;
   wire            pop;
   integer         i;

   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rd_ptr_ff];
   assign level     = cnt_ff;
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_ready & out_valid;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         cnt_ff    <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem_ff[i] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff         <= wr_ptr_ff + 1'b1;
         end
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         if (push & ~pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop & ~push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end

endmodule
`default_nettype wire

// ### ftlbm_mapper.v
/*
 * Four-tap link bit mapper: buffers four-pixel beats from the readout
 * logic and places them, with the line/frame/data qualifiers, on the
 * inputs of transmitters X and Y once per pixel clock.
 * Assumes the readout logic runs on clk, the pixel clock arrives from
 * outside and is much slower than clk, and APB is clocked by clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftlbm_consts.vh"

module ftlbm_mapper (
   input  wire                    clk,       // system clock, 125 MHz
   input  wire                    nrst,      // async reset, active low
   input  wire                    ce,        // clock enable, freezes state
   input  wire                    pix_clk,   // pixel clock from outside
   input  wire                    psel,      // apb select
   input  wire                    penable,   // apb access phase
   input  wire                    pwrite,    // apb direction
   input  wire [`FTL_ADDR_W-1:0]  paddr,     // apb byte address
   input  wire [31:0]             pwdata,    // apb write data
   output wire [31:0]             prdata,    // apb read data
   output wire                    pready,    // apb ready
   output wire                    pslverr,   // apb error, unmapped address or status write
   input  wire                    s_valid,   // beat valid from readout
   output wire                    s_ready,   // beat accepted
   input  wire [`FTL_PIX_W-1:0]   s_pix,     // four 12 bit samples, tap0 low
   input  wire                    s_last,    // last beat of the line
   output wire [`FTL_LINK_W-1:0]  tx_x_in,   // transmitter X inputs 0-27
   output wire                    tx_x_clk,  // transmitter X strobe
   output wire [`FTL_LINK_W-1:0]  tx_y_in,   // transmitter Y inputs 0-27
   output wire                    tx_y_clk   // transmitter Y strobe
);

   // ************************************************************
   // states
   // ************************************************************
   localparam ST_IDLE = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_LINE = 3'h4;

   // ************************************************************
   // link word builder
   // ************************************************************
   function [`FTL_LINK_W-1:0] link_word;
      input [7:0] pa;
      input [7:0] pb;
      input [7:0] pc;
      input       lv;
      input       fv;
      input       dv;
      integer     k;
      reg [39:0]  ma;
      reg [39:0]  mb;
      reg [39:0]  mc;
   begin
      ma = `FTL_MAP_A;
      mb = `FTL_MAP_B;
      mc = `FTL_MAP_C;
      link_word = {`FTL_LINK_W{1'b0}};
      for (k = 0; k < 8; k = k + 1)
      begin
         link_word[ma[k*5 +: 5]] = pa[k];
         link_word[mb[k*5 +: 5]] = pb[k];
         link_word[mc[k*5 +: 5]] = pc[k];
      end
      link_word[`FTL_TX_SPARE] = 1'b0;
      link_word[`FTL_TX_LVAL]  = lv;
      link_word[`FTL_TX_FVAL]  = fv;
      link_word[`FTL_TX_DVAL]  = dv;
   end
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   reg  [4:0]               ctrl_ff;
   reg  [15:0]              delay_ff;
   reg  [31:0]              prdata_ff;
   reg                      pslverr_ff;
   reg                      pix_s1_ff;
   reg                      pix_s2_ff;
   reg                      pix_s3_ff;
   reg                      strobe_ff;
   reg  [2:0]               state_ff;
   reg  [2:0]               nxt_state;
   reg  [15:0]              cnt_ff;
   reg  [15:0]              nxt_cnt;
   reg  [1:0]               dep_ff;
   reg  [1:0]               mode_ff;
   reg  [15:0]              lines_ff;
   reg  [`FTL_LINK_W-1:0]   tx_x_ff;
   reg  [`FTL_LINK_W-1:0]   tx_y_ff;
   reg                      emit;
   reg                      emit_lv;
   reg                      emit_dv;
   reg                      pop;
   reg  [7:0]               pa;
   reg  [7:0]               pb;
   reg  [7:0]               pc;
   reg  [7:0]               pd;
   reg  [7:0]               pe;
   reg  [7:0]               pf;
   wire [`FTL_WORD_W-1:0]   f_data;
   wire                     f_valid;
   wire [`FTL_FIFO_AW:0]    f_level;
   wire [`FTL_PIX_W-1:0]    red;
   wire                     tick;
   wire                     enable;
   wire                     raw_mode;
   wire                     f_last;
   wire                     setup;
   wire                     wr_access;
   wire [31:0]              status;

   // ************************************************************
   // beat buffer
   // ************************************************************
   ftlbm_fifo #(
      .WIDTH (`FTL_WORD_W),
      .DEPTH (`FTL_FIFO_DEPTH),
      .AW    (`FTL_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .ce        (ce),
      .in_valid  (s_valid),
      .in_ready  (s_ready),
      .in_data   ({s_last, s_pix}),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data),
      .level     (f_level)
   );

   assign f_last   = f_data[`FTL_LAST_BIT];
   assign enable   = ctrl_ff[`FTL_CTRL_EN];
   assign raw_mode = (mode_ff == `FTL_MODE_RAW) | (mode_ff == `FTL_MODE_ERAW);

   // ************************************************************
   // pixel clock synchroniser
   // ************************************************************
   // outputs change on the falling pixel edge so they are settled half
   // a period before the strobe rises at the transmitter
   assign tick = pix_s3_ff & ~pix_s2_ff;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pix_s1_ff <= 1'b0;
         pix_s2_ff <= 1'b0;
         pix_s3_ff <= 1'b0;
         strobe_ff <= 1'b0;
      end
      else if (ce)
      begin
         pix_s1_ff <= pix_clk;
         pix_s2_ff <= pix_s1_ff;
         pix_s3_ff <= pix_s2_ff;
         strobe_ff <= pix_s2_ff;
      end
   end

   assign tx_x_clk = strobe_ff;
   assign tx_y_clk = strobe_ff;

   // ************************************************************
   // depth reduction per tap
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < `FTL_TAPS; g = g + 1)
      begin : g_tap
         wire [`FTL_TAP_W-1:0] smp;
         assign smp = f_data[g*`FTL_TAP_W +: `FTL_TAP_W];
         assign red[g*`FTL_TAP_W +: `FTL_TAP_W] =
            (dep_ff == `FTL_DEP_10) ? (smp >> `FTL_DROP_10) :
            (dep_ff == `FTL_DEP_8)  ? (smp >> `FTL_DROP_8)  :
            smp;
      end
   endgenerate

   // ************************************************************
   // port byte assembly
   // ************************************************************
   always @*
   begin
      pa = red[7:0];
      pd = red[43:36];
      if (dep_ff == `FTL_DEP_8)
      begin
         pb = red[19:12];
         pc = red[31:24];
         pe = 8'h00;
         pf = 8'h00;
      end
      else
      begin
         // 10 bit values have zero upper bits, leaving those port bits unused
         pb = {red[23:20], red[11:8]};
         pc = red[19:12];
         pe = red[31:24];
         pf = {red[47:44], red[35:32]};
      end
   end

   // ************************************************************
   // line sequencer
   // ************************************************************
   always @*
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      emit      = 1'b0;
      emit_lv   = 1'b0;
      emit_dv   = 1'b0;
      pop       = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            emit = tick;
            if (tick & enable & f_valid)
            begin
               nxt_state = ST_WAIT;
               nxt_cnt   = delay_ff;
            end
         end
         ST_WAIT:
         begin
            if (tick)
            begin
               emit = 1'b1;
               if (cnt_ff == 16'h0000)
               begin
                  emit_lv   = 1'b1;
                  emit_dv   = 1'b1;
                  pop       = 1'b1;
                  nxt_state = f_last ? ST_IDLE : ST_LINE;
               end
               else
                  nxt_cnt = cnt_ff - 16'h0001;
            end
         end
         ST_LINE:
         begin
            if (tick)
            begin
               // an underrun keeps line valid high but data valid low
               emit    = 1'b1;
               emit_lv = 1'b1;
               emit_dv = f_valid;
               pop     = f_valid;
               if (f_valid & f_last)
                  nxt_state = ST_IDLE;
            end
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 16'h0000;
         dep_ff   <= `FTL_DEP_12;
         mode_ff  <= `FTL_MODE_RGB;
         lines_ff <= 16'h0000;
         tx_x_ff  <= {`FTL_LINK_W{1'b0}};
         tx_y_ff  <= {`FTL_LINK_W{1'b0}};
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         // depth and mode are frozen for the whole line
         if ((state_ff == ST_IDLE) & (nxt_state == ST_WAIT))
         begin
            dep_ff  <= ctrl_ff[`FTL_CTRL_DEP_HI:`FTL_CTRL_DEP_LO];
            mode_ff <= ctrl_ff[`FTL_CTRL_MOD_HI:`FTL_CTRL_MOD_LO];
         end
         if (pop & f_last)
            lines_ff <= lines_ff + 16'h0001;
         if (emit)
         begin
            if (emit_dv)
            begin
               tx_x_ff <= link_word(pa, pb, pc, 1'b1, raw_mode, 1'b1);
               tx_y_ff <= link_word(pd, pe, pf, 1'b1, raw_mode, 1'b1);
            end
            else
            begin
               tx_x_ff <= link_word(8'h00, 8'h00, 8'h00,
                                    emit_lv, emit_lv & raw_mode, 1'b0);
               tx_y_ff <= link_word(8'h00, 8'h00, 8'h00,
                                    emit_lv, emit_lv & raw_mode, 1'b0);
            end
         end
      end
   end

   assign tx_x_in = tx_x_ff;
   assign tx_y_in = tx_y_ff;

   // ************************************************************
   // apb slave
   // ************************************************************
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   assign pready    = 1'b1;
   assign prdata    = prdata_ff;
   assign pslverr   = pslverr_ff;

   assign status = {lines_ff,
                    8'h00,
                    f_level,
                    1'b0,
                    ~s_ready,
                    ~f_valid,
                    (state_ff != ST_IDLE)};

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_ff    <= `FTL_CTRL_RST;
         delay_ff   <= `FTL_DELAY_RST;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (setup)
         begin
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
            case (paddr)
               `FTL_REG_CTRL:   prdata_ff <= {27'h0000000, ctrl_ff};
               `FTL_REG_DELAY:  prdata_ff <= {16'h0000, delay_ff};
               `FTL_REG_STATUS: pslverr_ff <= pwrite;
               default:         pslverr_ff <= 1'b1;
            endcase
            if (~pwrite & (paddr == `FTL_REG_STATUS))
               prdata_ff <= status;
         end
         if (wr_access & (paddr == `FTL_REG_CTRL))
            ctrl_ff <= pwdata[`FTL_CTRL_MOD_HI:0];
         if (wr_access & (paddr == `FTL_REG_DELAY))
            delay_ff <= pwdata[15:0];
      end
   end

endmodule
`default_nettype wire

// ### tb_top.sv
/*
 * Testbench for the four-tap mapper: apb register access, one line per
 * depth and line mode through the fifo, words checked at the grabber.
 * Assumes ftlbm_consts.vh on the include path; ce is held high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftlbm_consts.vh"
module tb_top;
logic        clk, nrst, ce, pix_clk, psel, penable, pwrite, s_valid, s_last, raw_mode;
logic [7:0]  paddr;
logic [31:0] pwdata, rd;
logic [47:0] s_pix, pix;
logic        err, full_seen;
wire  [31:0] prdata;
wire         pready, pslverr, s_ready, tx_x_clk, tx_y_clk, acc_valid;
wire  [27:0] tx_x_in, tx_y_in, acc_x, acc_y;
int          n_errors, compares, m, d, k;
logic [55:0] expq[$];
localparam int MP[24] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8, 9, 12, 13, 14, 10, 11,
                          15, 18, 19, 20, 21, 22, 16, 17};
ftlbm_mapper ftlbm_mapper_i (.clk(clk), .nrst(nrst), .ce(ce), .pix_clk(pix_clk),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_valid(s_valid),
   .s_ready(s_ready), .s_pix(s_pix), .s_last(s_last), .tx_x_in(tx_x_in),
   .tx_x_clk(tx_x_clk), .tx_y_in(tx_y_in), .tx_y_clk(tx_y_clk));
ftlbm_fg_model ftlbm_fg_model_i (.clk(clk), .nrst(nrst), .strobe(tx_x_clk),
   .raw_mode(raw_mode), .x_in(tx_x_in), .y_in(tx_y_in), .acc_valid(acc_valid),
   .acc_x(acc_x), .acc_y(acc_y));
// ************************************************************
// clocks, helpers
// ************************************************************
initial
begin
   clk = 1'b0;
   forever #4 clk = ~clk;
end
// pixel clock free running, phase unrelated to clk
initial
begin
   pix_clk = 1'b0;
   #13;
   forever #40 pix_clk = ~pix_clk;
end
task automatic cmp_word(input logic [55:0] e, input logic [55:0] g);
   compares++;
   if (e !== g)
   begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
   end
endtask
task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
   compares++;
   if (e !== g)
   begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
   end
endtask
task automatic end_sim;
   $display("errors %0d compares %0d", n_errors, compares);
   if (n_errors == 0 && compares > 0)
      $display("bench passed");
   else
      $display("bench failed");
   $finish;
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
   psel    <= 1'b1;
   penable <= 1'b0;
   pwrite  <= w;
   paddr   <= a;
   pwdata  <= dat;
   @(posedge clk);
   penable <= 1'b1;
   // answer and read data are taken only at the edge that sees pready high
   @(posedge clk);
   while (pready !== 1'b1) @(posedge clk);
   rd  = prdata;
   err = pslverr;
   psel    <= 1'b0;
   penable <= 1'b0;
   // one idle edge, so a following call never re-drives psel in this step
   @(posedge clk);
endtask
task automatic push(input logic [47:0] p, input logic l);
   s_valid <= 1'b1;
   s_pix   <= p;
   s_last  <= l;
   @(negedge clk);
   while (s_ready !== 1'b1)
   begin
      full_seen = 1'b1;
      @(negedge clk);
   end
   @(posedge clk);
endtask
function automatic logic [27:0] lw(input logic [23:0] p, input logic fv);
   logic [27:0] w;
   w = 28'h0;
   for (int i = 0; i < 24; i++) w[MP[i]] = p[i];
   w[26:24] = {1'b1, fv, 1'b1};
   return w;
endfunction
function automatic logic [55:0] ex(input logic [47:0] p, input int dp, input logic fv);
   logic [11:0] v[4];
   logic [23:0] a, b;
   for (int i = 0; i < 4; i++) v[i] = p[12*i +: 12] >> (dp == 1 ? 2 : dp == 2 ? 4 : 0);
   a = (dp == 2) ? {v[2][7:0], v[1][7:0], v[0][7:0]}
      : {v[1][7:0], v[1][11:8], v[0][11:8], v[0][7:0]};
   b = (dp == 2) ? {16'h0, v[3][7:0]}
      : {v[3][11:8], v[2][11:8], v[2][7:0], v[3][7:0]};
   return {lw(b, fv), lw(a, fv)};
endfunction
// ************************************************************
// result watcher, watchdog
// ************************************************************
always @(negedge clk)
   if (acc_valid === 1'b1)
      cmp_word(expq.size() ? expq.pop_front() : 56'hx, {acc_y, acc_x});
initial
begin
   #200000;
   n_errors++;
   end_sim;
end
// ************************************************************
// main sequence
// ************************************************************
initial
begin
   {nrst, psel, penable, pwrite, s_valid, s_last, raw_mode, full_seen} = 8'h00;
   {paddr, pwdata, s_pix} = 88'h0;
   ce = 1'b1;
   n_errors = 0;
   compares = 0;
   void'($urandom(35));
   repeat (20) @(posedge clk);
   cmp_word(56'h0, {tx_y_in, tx_x_in});
   nrst <= 1'b1;
   @(posedge clk);
   apb(1'b0, `FTL_REG_CTRL, 32'h0);
   cmp_reg(33'h0, {err, rd});
   apb(1'b0, `FTL_REG_STATUS, 32'h0);
   cmp_reg(33'h2, {err, rd});
   apb(1'b0, 8'h0c, 32'h0);
   cmp_reg(33'h100000000, {err, rd});
   apb(1'b1, `FTL_REG_STATUS, 32'hffff);
   cmp_reg(33'h100000000, {err, 32'h0});
   apb(1'b1, `FTL_REG_DELAY, 32'h2);
   apb(1'b0, `FTL_REG_DELAY, 32'h0);
   cmp_reg(33'h2, {err, rd});
   for (m = 0; m < 3; m++)
      for (d = 0; d < 3; d++)
      begin
         raw_mode <= (m != 0);
         apb(1'b1, `FTL_REG_CTRL, 32'((m << 3) | (d << 1) | 1));
         // ten beats against eight words of fifo: the source must stall
         for (k = 0; k < 10; k++)
         begin
            pix[47:24] = 24'($urandom());
            pix[23:0]  = 24'($urandom());
            expq.push_back(ex(pix, d, m != 0));
            push(pix, k == 9);
         end
         s_valid <= 1'b0;
         s_last  <= 1'b0;
         for (k = 0; k < 5000 && expq.size() != 0; k++) @(posedge clk);
         repeat (40) @(posedge clk);
      end
   cmp_reg(33'h0, {1'b0, 32'(expq.size())});
   cmp_reg(33'h1, {32'h0, full_seen});
   apb(1'b0, `FTL_REG_STATUS, 32'h0);
   cmp_reg({1'b0, 16'd9, 16'h0002}, {err, rd});
   end_sim;
end
endmodule
`default_nettype wire
